// ### verilog/scan_ctrl_regs.svh
// Purpose: register map and field constants of the channel scan control block
// Assumes: register index times four is the byte address
// Notes:   definitions only
`ifndef SCAN_CTRL_REGS_SVH
`define SCAN_CTRL_REGS_SVH

`define SCAN_IDX_INCLUDE    6'h01
`define SCAN_IDX_POWER_DOWN 6'h02
`define SCAN_IDX_CONTROL    6'h10
`define SCAN_IDX_STATUS     6'h11

`define SCAN_RST_INCLUDE    8'hff
`define SCAN_RST_POWER_DOWN 8'h00
`define SCAN_RST_CONTROL    8'h00

`define SCAN_CTL_MANUAL_BIT 0
`define SCAN_CTL_CHAN_LSB   4
`define SCAN_CTL_CHAN_MSB   6

`define SCAN_STS_CHAN_LSB   0
`define SCAN_STS_CHAN_MSB   2
`define SCAN_STS_INVALID    4
`define SCAN_STS_MANUAL     5

`define SCAN_DEFAULT_CHAN   3'h0
`define SCAN_RESP_OKAY      2'h0
`define SCAN_RESP_SLVERR    2'h2

`endif

// ### verilog/scan_ctrl_pkg.sv
// Purpose: types shared by the channel scan control block
// Assumes: eight channel slots at most
// Notes:   constants live in scan_ctrl_regs.svh
package scan_ctrl_pkg;

  typedef enum logic [1:0]
  {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

  typedef enum logic [1:0]
  {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_t;

  typedef struct packed
  {
    logic [2:0] chan;
    logic       invalid;
    logic       go;
  } scan_pick_t;

endpackage

// ### verilog/auto_scan_channel_control.sv
// Purpose: channel include and power-down control for the automatic scan
// Assumes: AXI4-Lite register access, conv_start from logic on ref_clk
// Notes:   four-channel build by NUM_CHAN = 4
//
// What this block does
// - include bit n puts channel n in scan
// - include mask read/write, resets to all ones
// - power-down mask at index 02h, read/write
// - power-down bit set: front end off, skipped
// - power-down bit clear: powered, eligible if included
// - power-down mask resets to 00h
// - all channels off: result flagged invalid
// - manual pick of powered-down channel gives invalid
// - absent channel bits ignore writes
// - absent channel bits read as ones
// - auto scan ascends then wraps, next eligible channel each conversion
// - empty include mask converts channel 0
// - include mask at index 01h
`timescale 1ns/1ps
`include "scan_ctrl_regs.svh"

module auto_scan_channel_control
#(
  parameter int NUM_CHAN = 8
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        conv_start,
  output logic [2:0]       conv_chan,
  output logic             conv_go,
  output logic             result_invalid,
  output logic [7:0]       front_end_off
);

  localparam logic [7:0] PRESENT = 8'((9'h1 << NUM_CHAN) - 9'h1);

  // register bank
  logic [7:0]                include_q, include_d;
  logic [7:0]                pd_q, pd_d;
  logic [7:0]                ctrl_q, ctrl_d;
  logic [7:0]                fe_off_q, fe_off_d;

  // write channel
  scan_ctrl_pkg::wr_state_t  wr_q, wr_d;
  logic                      aw_held_q, aw_held_d;
  logic                      w_held_q, w_held_d;
  logic [5:0]                aw_idx_q, aw_idx_d;
  logic [7:0]                wbyte_q, wbyte_d;
  logic                      wlane_q, wlane_d;
  logic                      awready_q, awready_d;
  logic                      wready_q, wready_d;
  logic                      bvalid_q, bvalid_d;
  logic [1:0]                bresp_q, bresp_d;

  // read channel
  scan_ctrl_pkg::rd_state_t  rd_q, rd_d;
  logic                      arready_q, arready_d;
  logic                      rvalid_q, rvalid_d;
  logic [31:0]               rdata_q, rdata_d;
  logic [1:0]                rresp_q, rresp_d;

  // scan engine
  scan_ctrl_pkg::scan_pick_t pick_q, pick_d;

  logic                      aw_take, w_take, have_aw, have_w, eff_lane, do_write;
  logic [5:0]                eff_idx;
  logic [7:0]                eff_byte;

  // write handshake: address and data in either order
  always_comb
  begin
    aw_take   = s_axi_awvalid & awready_q;
    w_take    = s_axi_wvalid & wready_q;
    have_aw   = aw_held_q | aw_take;
    have_w    = w_held_q | w_take;
    eff_idx   = aw_held_q ? aw_idx_q : s_axi_awaddr[7:2];
    eff_byte  = w_held_q ? wbyte_q : s_axi_wdata[7:0];
    eff_lane  = w_held_q ? wlane_q : s_axi_wstrb[0];
    do_write  = (wr_q == scan_ctrl_pkg::WR_IDLE) & have_aw & have_w;
    wr_d      = wr_q;
    aw_held_d = aw_held_q;
    w_held_d  = w_held_q;
    aw_idx_d  = aw_idx_q;
    wbyte_d   = wbyte_q;
    wlane_d   = wlane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    case (wr_q)
      scan_ctrl_pkg::WR_IDLE:
      begin
        if (aw_take)
        begin
          aw_held_d = 1'b1;
          aw_idx_d  = s_axi_awaddr[7:2];
        end
        if (w_take)
        begin
          w_held_d = 1'b1;
          wbyte_d  = s_axi_wdata[7:0];
          wlane_d  = s_axi_wstrb[0];
        end
        if (do_write)
        begin
          aw_held_d = 1'b0;
          w_held_d  = 1'b0;
          bvalid_d  = 1'b1;
          wr_d      = scan_ctrl_pkg::WR_RESP;
          if (eff_idx == `SCAN_IDX_INCLUDE || eff_idx == `SCAN_IDX_POWER_DOWN ||
              eff_idx == `SCAN_IDX_CONTROL || eff_idx == `SCAN_IDX_STATUS)
            bresp_d = `SCAN_RESP_OKAY;
          else
            bresp_d = `SCAN_RESP_SLVERR;
        end
      end
      scan_ctrl_pkg::WR_RESP:
      begin
        if (s_axi_bready)
        begin
          bvalid_d = 1'b0;
          wr_d     = scan_ctrl_pkg::WR_IDLE;
        end
      end
      default:
      begin
        wr_d     = scan_ctrl_pkg::WR_IDLE;
        bvalid_d = 1'b0;
      end
    endcase
    awready_d = (wr_d == scan_ctrl_pkg::WR_IDLE) & ~aw_held_d;
    wready_d  = (wr_d == scan_ctrl_pkg::WR_IDLE) & ~w_held_d;
  end

  // register updates; absent channel bits keep their reset value
  always_comb
  begin
    include_d = include_q;
    pd_d      = pd_q;
    ctrl_d    = ctrl_q;
    if (do_write && eff_lane)
    begin
      if (eff_idx == `SCAN_IDX_INCLUDE)
        include_d = (eff_byte & PRESENT) | (include_q & ~PRESENT);
      if (eff_idx == `SCAN_IDX_POWER_DOWN)
        pd_d = (eff_byte & PRESENT) | (pd_q & ~PRESENT);
      if (eff_idx == `SCAN_IDX_CONTROL)
        ctrl_d = eff_byte;
    end
    fe_off_d = pd_q & PRESENT;
  end

  // read path
  always_comb
  begin
    rd_d      = rd_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    case (rd_q)
      scan_ctrl_pkg::RD_IDLE:
      begin
        if (s_axi_arvalid && arready_q) // ready is low on the first edge after reset
        begin
          rd_d     = scan_ctrl_pkg::RD_DATA;
          rvalid_d = 1'b1;
          rresp_d  = `SCAN_RESP_OKAY;
          rdata_d  = 32'h0;
          case (s_axi_araddr[7:2])
            `SCAN_IDX_INCLUDE:    rdata_d[7:0] = include_q | ~PRESENT;
            `SCAN_IDX_POWER_DOWN: rdata_d[7:0] = pd_q | ~PRESENT;
            `SCAN_IDX_CONTROL:    rdata_d[7:0] = ctrl_q;
            `SCAN_IDX_STATUS:
            begin
              rdata_d[`SCAN_STS_CHAN_MSB:`SCAN_STS_CHAN_LSB] = pick_q.chan;
              rdata_d[`SCAN_STS_INVALID] = pick_q.invalid;
              rdata_d[`SCAN_STS_MANUAL]  = ctrl_q[`SCAN_CTL_MANUAL_BIT];
            end
            default:              rresp_d = `SCAN_RESP_SLVERR;
          endcase
        end
      end
      scan_ctrl_pkg::RD_DATA:
      begin
        if (s_axi_rready)
        begin
          rvalid_d = 1'b0;
          rd_d     = scan_ctrl_pkg::RD_IDLE;
        end
      end
      default:
      begin
        rd_d     = scan_ctrl_pkg::RD_IDLE;
        rvalid_d = 1'b0;
      end
    endcase
    arready_d = (rd_d == scan_ctrl_pkg::RD_IDLE);
  end

  // scan selection
  logic [7:0] eligible, incl_live;
  logic       all_off;
  logic [2:0] man_chan;

  always_comb
  begin
    logic [2:0] cand, found_chan;
    logic       found;
    cand       = 3'h0;
    found_chan = `SCAN_DEFAULT_CHAN;
    found      = 1'b0;
    incl_live  = include_q & PRESENT;
    eligible   = incl_live & ~pd_q;
    all_off    = ((pd_q & PRESENT) == PRESENT);
    man_chan   = ctrl_q[`SCAN_CTL_CHAN_MSB:`SCAN_CTL_CHAN_LSB];
    // search starts after the current channel, so it rises then wraps
    for (int k = 1; k <= 8; k++)
    begin
      cand = 3'(pick_q.chan + 3'(k));
      if (!found && eligible[cand])
      begin
        found_chan = cand;
        found      = 1'b1;
      end
    end
    pick_d    = pick_q;
    pick_d.go = 1'b0;
    if (conv_start)
    begin
      pick_d.go = 1'b1;
      if (ctrl_q[`SCAN_CTL_MANUAL_BIT])
      begin
        // the host must not pick a powered-down channel; flag it if it does
        pick_d.chan    = man_chan;
        pick_d.invalid = all_off | pd_q[man_chan] | ~PRESENT[man_chan];
      end
      else if (incl_live == 8'h00)
      begin
        pick_d.chan    = `SCAN_DEFAULT_CHAN;
        pick_d.invalid = all_off | pd_q[0];
      end
      else
      begin
        // included but all powered down: fall back to channel 0, invalid
        pick_d.chan    = found ? found_chan : `SCAN_DEFAULT_CHAN;
        pick_d.invalid = all_off | ~found;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      include_q <= `SCAN_RST_INCLUDE;
      pd_q      <= `SCAN_RST_POWER_DOWN;
      ctrl_q    <= `SCAN_RST_CONTROL;
      fe_off_q  <= `SCAN_RST_POWER_DOWN;
      pick_q    <= '0;
      wr_q      <= scan_ctrl_pkg::WR_IDLE;
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_idx_q  <= 6'h0;
      wbyte_q   <= 8'h0;
      wlane_q   <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      rd_q      <= scan_ctrl_pkg::RD_IDLE;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= 2'h0;
    end
    else
    begin
      include_q <= include_d;
      pd_q      <= pd_d;
      ctrl_q    <= ctrl_d;
      fe_off_q  <= fe_off_d;
      pick_q    <= pick_d;
      wr_q      <= wr_d;
      aw_held_q <= aw_held_d;
      w_held_q  <= w_held_d;
      aw_idx_q  <= aw_idx_d;
      wbyte_q   <= wbyte_d;
      wlane_q   <= wlane_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rd_q      <= rd_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  assign s_axi_awready  = awready_q;
  assign s_axi_wready   = wready_q;
  assign s_axi_bvalid   = bvalid_q;
  assign s_axi_bresp    = bresp_q;
  assign s_axi_arready  = arready_q;
  assign s_axi_rvalid   = rvalid_q;
  assign s_axi_rdata    = rdata_q;
  assign s_axi_rresp    = rresp_q;
  assign conv_chan      = pick_q.chan;
  assign conv_go        = pick_q.go;
  assign result_invalid = pick_q.invalid;
  assign front_end_off  = fe_off_q;

endmodule

// ### test/scan_ctrl_monitor.sv
// Purpose: port checks of the scan control block
// Assumes: one clock, reset active high
// Notes:   bound from the bench top
`timescale 1ns/1ps
module scan_ctrl_monitor
#(
  parameter int NUM_CHAN = 8
)
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       conv_start,
  input wire logic       conv_go,
  input wire logic [2:0] conv_chan,
  input wire logic       result_invalid,
  input wire logic [7:0] front_end_off
);
  localparam logic [7:0] PRES = 8'hff >> (8 - NUM_CHAN);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  go_after_start_a: assert property (conv_start |=> conv_go) else $error("no go");
  go_cause_a: assert property (conv_go |-> $past(conv_start)) else $error("stray go");
  chan_hold_a: assert property (!conv_go |-> $stable(conv_chan)) else $error("chan moved");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("no read answer");
  write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b stuck");
  all_off_a: assert property (conv_go && (front_end_off & PRES) == PRES |-> result_invalid)
    else $error("all off valid");
  off_skipped_a: assert property (conv_go && !result_invalid |-> !front_end_off[conv_chan])
    else $error("off chan picked");
  absent_quiet_a: assert property ((front_end_off & ~PRES) == 8'h00) else $error("absent off");
  cover property (conv_go && result_invalid);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (conv_start ##1 conv_start);
endmodule

// ### test/scan_host_model.sv
// Purpose: host side of the register bus and scan strobe
// Assumes: drives right after rising edges only
// Notes:   waits without limit, the bench watchdog cuts hangs
`timescale 1ns/1ps
module scan_host_model
(
  input wire logic        ref_clk,
  output logic [31:0]     s_axi_awaddr,
  output logic            s_axi_awvalid,
  input wire logic        s_axi_awready,
  output logic [31:0]     s_axi_wdata,
  output logic [3:0]      s_axi_wstrb,
  output logic            s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  output logic            s_axi_bready,
  output logic [31:0]     s_axi_araddr,
  output logic            s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  output logic            s_axi_rready,
  output logic            conv_start,
  input wire logic        conv_go,
  input wire logic [2:0]  conv_chan,
  input wire logic        result_invalid
);
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, conv_start} = '0;
  end
  // address and data go out together, each dropped on its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] x, input logic [3:0] s, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= x;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) r = s_axi_bresp;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      x = s_axi_rdata;
      r = s_axi_rresp;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  task automatic conv(output logic [2:0] c, output logic v, output logic g);
    @(posedge ref_clk);
    conv_start <= 1'b1;
    @(posedge ref_clk);
    conv_start <= 1'b0;
    @(posedge ref_clk);
    {c, v, g} = {conv_chan, result_invalid, conv_go};
  endtask
  // strobe held over two edges: two picks back to back
  task automatic conv_pair(output logic [2:0] c0, output logic [2:0] c1);
    @(posedge ref_clk);
    conv_start <= 1'b1;
    @(posedge ref_clk);
    @(posedge ref_clk);
    conv_start <= 1'b0;
    c0 = conv_chan;
    @(posedge ref_clk);
    c1 = conv_chan;
  endtask
endmodule

// ### test/auto_scan_channel_control_tb_top.sv
// Purpose: self-checking bench of the scan control block
// Assumes: four-channel build, host model drives the bus
// Notes:   absent bits read as ones
`timescale 1ns/1ps
`include "scan_ctrl_regs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module auto_scan_channel_control_tb_top;
  localparam int NC = 4;
  localparam logic [7:0] P = 8'hff >> (8 - NC);
  localparam logic [7:0] A_INC = {`SCAN_IDX_INCLUDE, 2'b00};
  localparam logic [7:0] A_PD = {`SCAN_IDX_POWER_DOWN, 2'b00};
  localparam logic [7:0] A_CTL = {`SCAN_IDX_CONTROL, 2'b00};
  localparam logic [7:0] A_STS = {`SCAN_IDX_STATUS, 2'b00};
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [2:0]  conv_chan, c, cur;
  logic [7:0]  front_end_off, inc_s, pd_s;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, conv_start, conv_go, result_invalid, v, g;
  int          errors = 0;
  int          n_compared = 0;
  always #10 ref_clk = ~ref_clk;
  auto_scan_channel_control #(.NUM_CHAN(NC)) dut (.*);
  scan_host_model host (.*);
  task automatic summarize();
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] x);
    host.wr(a, {24'h0, x}, 4'h1, r);
    `CHK(r, `SCAN_RESP_OKAY)
    if (a == A_INC) inc_s = x;
    if (a == A_PD) pd_s = x;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    host.rd(a, d, r);
    `CHK(d, {24'h0, x})
  endtask
  // own reckoning of the next pick, first eligible after the last one, wrapping from 7 to 0
  task automatic cv(input logic ev);
    logic [7:0] e;
    e = inc_s & ~pd_s & P;
    for (int i = 1; i <= 8; i++)
    begin
      if (e[(cur + i) % 8])
      begin
        cur = 3'((cur + i) % 8);
        break;
      end
    end
    if (e == 8'h00) cur = `SCAN_DEFAULT_CHAN;
    host.conv(c, v, g);
    `CHK(g, 1'b1)
    `CHK(c, cur)
    `CHK(v, ev)
  endtask
  task automatic t_regs();
    rdc(A_INC, 8'hff);
    rdc(A_PD, ~P);
    wr8(A_INC, 8'h5a);
    rdc(A_INC, 8'h5a | ~P);
    wr8(A_PD, 8'ha5);
    rdc(A_PD, 8'ha5 | ~P);
    `CHK(front_end_off, 8'ha5 & P)
    host.wr(8'h0c, 32'hff, 4'h1, r);
    `CHK(r, `SCAN_RESP_SLVERR)
    host.rd(8'h0c, d, r);
    `CHK({d, r}, {32'h0, `SCAN_RESP_SLVERR})
    host.wr(A_INC, 32'h0, 4'h0, r);
    `CHK(r, `SCAN_RESP_OKAY)
    rdc(A_INC, 8'h5a | ~P);
  endtask
  task automatic t_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    {cur, inc_s, pd_s} = {3'h0, 8'hff, 8'h00};
    @(posedge ref_clk);
    `CHK({front_end_off, conv_go, result_invalid}, 10'h000)
    rdc(A_INC, 8'hff);
    rdc(A_PD, ~P);
    cv(1'b0);
  endtask
  task automatic t_scan();
    wr8(A_INC, 8'h0d);
    wr8(A_PD, 8'h00);
    repeat (5) cv(1'b0);
    host.conv_pair(c, d[2:0]);
    `CHK({c, d[2:0]}, {3'h0, 3'h2})
    cur = 3'h2;
    wr8(A_PD, 8'h04);
    repeat (3) cv(1'b0);
    wr8(A_INC, 8'h00);
    repeat (2) cv(1'b0);
    wr8(A_INC, 8'hff);
    wr8(A_PD, 8'hff);
    cv(1'b1);
  endtask
  task automatic t_manual();
    wr8(A_CTL, 8'h31);
    wr8(A_PD, 8'h08);
    host.conv(c, v, g);
    `CHK({c, v}, {3'h3, 1'b1})
    rdc(A_CTL, 8'h31);
    wr8(A_STS, 8'h00);
    rdc(A_STS, 8'h33);
    wr8(A_PD, 8'h00);
    host.conv(c, v, g);
    `CHK({c, v}, {3'h3, 1'b0})
    wr8(A_CTL, 8'h51);
    host.conv(c, v, g);
    `CHK({c, v}, {3'h5, 1'b1})
    wr8(A_CTL, 8'h00);
    cur = 3'h5;
    cv(1'b0);
  endtask
  initial
  begin
    {cur, inc_s, pd_s} = {3'h0, 8'hff, 8'h00};
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    `CHK(front_end_off, 8'h00)
    t_regs();
    t_reset();
    t_scan();
    t_manual();
    summarize();
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    summarize();
  end
endmodule
bind auto_scan_channel_control scan_ctrl_monitor #(.NUM_CHAN(NUM_CHAN)) mon (.*);
